/* File: core/parallel_port_buffer_status.sv */
`timescale 1ns/100ps

module parallel_port_buffer_status (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic [11:0]                  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [11:0]                  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire parallel_port_pkg::host_req_t hostReq,
  output logic [7:0]                        hostRdData,
  output logic [15:0]                       addrOut,
  output logic [1:0]                        chipSelect,
  output logic                              ttlInputSelect,
  output logic                              irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  inData [4];
  logic [7:0]  outData [4];
  logic [3:0]  inFull;
  logic [3:0]  outEmpty;
  logic        inOverflow;
  logic        outUnderflow;
  logic [3:0]  ctrl;
  logic [3:0]  evStat;
  logic [3:0]  evMask;
  logic        awHeld;
  logic        wHeld;
  logic [11:0] wAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  logic [3:0]  inWritable;
  logic [3:0]  outReadable;
  logic [3:0]  hostSlotHot;
  logic        hostWrOk;
  logic        hostWrOver;
  logic        hostRdOk;
  logic        hostRdUnder;
  logic        doWrite;
  logic        doRead;
  logic [3:0]  cpuInRead;
  logic [3:0]  cpuOutWrite;
  logic        allInFull;
  logic        allOutEmpty;
  logic [7:0]  inStatus;
  logic [7:0]  outStatus;
  logic [31:0] next_rdata;
  logic        next_rdErr;
  logic        writeMapped;
  parallel_port_pkg::port_mode_t mode;

  // ----------------------------------------------------------------
  // mode and slot groups
  // ----------------------------------------------------------------
  always_comb begin
    if (ctrl[parallel_port_pkg::CTRL_MASTER]) begin
      mode = parallel_port_pkg::MODE_MASTER;
    end else if (ctrl[parallel_port_pkg::CTRL_BUFFERED]) begin
      mode = parallel_port_pkg::MODE_BUFFERED;
    end else begin
      mode = parallel_port_pkg::MODE_SLAVE;
    end
  end

  always_comb begin
    case (mode)
      parallel_port_pkg::MODE_BUFFERED: begin
        inWritable  = parallel_port_pkg::ALL_SLOTS;
        outReadable = parallel_port_pkg::ALL_SLOTS;
      end
      parallel_port_pkg::MODE_MASTER: begin
        inWritable  = parallel_port_pkg::PAIR_SLOTS;
        outReadable = 4'h0;
      end
      default: begin
        inWritable  = parallel_port_pkg::PAIR_SLOTS;
        outReadable = parallel_port_pkg::PAIR_SLOTS;
      end
    endcase
  end

  assign hostSlotHot = 4'h1 << hostReq.slot;
  assign hostWrOk    = hostReq.wr && |(hostSlotHot & inWritable & ~inFull);
  assign hostWrOver  = hostReq.wr && |(hostSlotHot & inWritable & inFull);
  assign hostRdOk    = hostReq.rd && |(hostSlotHot & outReadable & ~outEmpty);
  assign hostRdUnder = hostReq.rd && |(hostSlotHot & outReadable & outEmpty);

  assign allInFull   = &(inFull | ~inWritable);
  assign allOutEmpty = &(outEmpty | ~outReadable);
  assign inStatus    = {allInFull, inOverflow, 2'b00, inFull};
  assign outStatus   = {allOutEmpty, outUnderflow, 2'b00, outEmpty};

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign writeMapped = (wAddr[11:5] == parallel_port_pkg::INPUT_DATA_BASE[11:5])
    || wAddr == parallel_port_pkg::CONTROL_ADDR
    || wAddr == parallel_port_pkg::INPUT_STAT_ADDR
    || wAddr == parallel_port_pkg::OUTPUT_STAT_ADDR
    || wAddr == parallel_port_pkg::EVENT_STAT_ADDR
    || wAddr == parallel_port_pkg::EVENT_MASK_ADDR;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= parallel_port_pkg::RESP_OKAY;
      wAddr         <= 12'h000;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld        <= 1'b1;
        s_axi_awready <= 1'b0;
        wAddr         <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld        <= 1'b1;
        s_axi_wready <= 1'b0;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= writeMapped ? parallel_port_pkg::RESP_OKAY
                                    : parallel_port_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awHeld        <= 1'b0;
        wHeld         <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  assign doRead = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_rdata = 32'h00000000;
    next_rdErr = 1'b0;
    if (s_axi_araddr[11:4] == parallel_port_pkg::INPUT_DATA_BASE[11:4]) begin
      next_rdata[7:0] = inData[s_axi_araddr[3:2]];
    end else if (s_axi_araddr[11:4]
                 == parallel_port_pkg::OUTPUT_DATA_BASE[11:4]) begin
      next_rdata[7:0] = outData[s_axi_araddr[3:2]];
    end else begin
      case ({s_axi_araddr[11:2], 2'b00})
        parallel_port_pkg::CONTROL_ADDR:     next_rdata[3:0] = ctrl;
        parallel_port_pkg::INPUT_STAT_ADDR:  next_rdata[7:0] = inStatus;
        parallel_port_pkg::OUTPUT_STAT_ADDR: next_rdata[7:0] = outStatus;
        parallel_port_pkg::EVENT_STAT_ADDR:  next_rdata[3:0] = evStat;
        parallel_port_pkg::EVENT_MASK_ADDR:  next_rdata[3:0] = evMask;
        default:                             next_rdErr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= parallel_port_pkg::RESP_OKAY;
    end else begin
      if (doRead) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= next_rdErr ? parallel_port_pkg::RESP_SLVERR
                                    : parallel_port_pkg::RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // cpu side effects on the data slots
  // ----------------------------------------------------------------
  always_comb begin
    cpuInRead   = 4'h0;
    cpuOutWrite = 4'h0;
    if (doRead && s_axi_araddr[11:4]
        == parallel_port_pkg::INPUT_DATA_BASE[11:4]) begin
      cpuInRead = 4'h1 << s_axi_araddr[3:2];
    end
    if (doWrite && wStrb[0] && wAddr[11:4]
        == parallel_port_pkg::OUTPUT_DATA_BASE[11:4]) begin
      cpuOutWrite = 4'h1 << wAddr[3:2];
    end
  end

  // ----------------------------------------------------------------
  // byte storage: four input and four output slots
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        inData[i]  <= 8'h00;
        outData[i] <= 8'h00;
      end
    end else begin
      if (hostWrOk) begin
        inData[hostReq.slot] <= hostReq.data;
      end
      for (int i = 0; i < 4; i++) begin
        if (cpuOutWrite[i]) begin
          outData[i] <= wData[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-slot flags, host set wins over cpu clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inFull   <= parallel_port_pkg::IN_FULL_RESET;
      outEmpty <= parallel_port_pkg::OUT_EMPTY_RESET;
    end else begin
      inFull   <= (inFull & ~cpuInRead)
                | (hostWrOk ? hostSlotHot : 4'h0);
      outEmpty <= (outEmpty & ~cpuOutWrite)
                | (hostRdOk ? hostSlotHot : 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // sticky overflow and underflow, cleared by writing zero
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inOverflow   <= 1'b0;
      outUnderflow <= 1'b0;
    end else begin
      if (hostWrOver) begin
        inOverflow <= 1'b1;
      end else if (doWrite && wStrb[0]
                   && wAddr == parallel_port_pkg::INPUT_STAT_ADDR) begin
        inOverflow <= wData[parallel_port_pkg::FLOW_BIT];
      end
      if (hostRdUnder) begin
        outUnderflow <= 1'b1;
      end else if (doWrite && wStrb[0]
                   && wAddr == parallel_port_pkg::OUTPUT_STAT_ADDR) begin
        outUnderflow <= wData[parallel_port_pkg::FLOW_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // control, event status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl   <= parallel_port_pkg::CTRL_RESET;
      evMask <= 4'h0;
      evStat <= 4'h0;
      irq    <= 1'b0;
    end else begin
      if (doWrite && wStrb[0] && wAddr == parallel_port_pkg::CONTROL_ADDR) begin
        ctrl <= wData[3:0];
      end
      if (doWrite && wStrb[0]
          && wAddr == parallel_port_pkg::EVENT_MASK_ADDR) begin
        evMask <= wData[3:0];
      end
      evStat <= (evStat & ~((doWrite && wStrb[0]
                 && wAddr == parallel_port_pkg::EVENT_STAT_ADDR)
                 ? wData[3:0] : 4'h0))
              | {hostRdUnder, hostWrOver, hostRdOk, hostWrOk};
      irq <= |(evStat & evMask);
    end
  end

  // ----------------------------------------------------------------
  // host read data, address and pad outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hostRdData     <= 8'h00;
      addrOut        <= 16'h0000;
      chipSelect     <= 2'b00;
      ttlInputSelect <= 1'b0;
    end else begin
      ttlInputSelect <= ctrl[parallel_port_pkg::CTRL_TTL];
      if (hostReq.rd) begin
        hostRdData <= (mode == parallel_port_pkg::MODE_MASTER)
                    ? inData[hostReq.slot] : outData[hostReq.slot];
      end
      if (mode == parallel_port_pkg::MODE_MASTER) begin
        if (ctrl[parallel_port_pkg::CTRL_CS_ENABLE]) begin
          chipSelect <= outData[1][7:6];
          addrOut    <= {2'b00, outData[1][5:0], outData[0]};
        end else begin
          chipSelect <= 2'b00;
          addrOut    <= {outData[1], outData[0]};
        end
      end else begin
        chipSelect <= 2'b00;
        addrOut    <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  all_full_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    inStatus[7] == ((inFull & inWritable) == inWritable))
    else $error("all-inputs-full wrong");

  overflow_set_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n) hostWrOver |=> inOverflow && $stable(inData[0]))
    else $error("overflow not set");

  full_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|cpuInRead && !hostWrOk) |=> !(|(inFull & $past(cpuInRead))))
    else $error("full flag not cleared by read");

  all_empty_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !outStatus[7] |-> |(outReadable & ~outEmpty))
    else $error("all-outputs-empty wrong");

  underflow_set_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n) hostRdUnder |=> outUnderflow ##1 outUnderflow
    || $past(doWrite))
    else $error("underflow not held");

  empty_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|cpuOutWrite && !hostRdOk) |=> !(|(outEmpty & $past(cpuOutWrite))))
    else $error("empty flag not cleared by write");

  zero_bits_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_axi_rvalid && $past(doRead) && $past(s_axi_araddr[11:2])
    == parallel_port_pkg::OUTPUT_STAT_ADDR[11:2]
    |-> s_axi_rdata[5:4] == 2'b00)
    else $error("reserved status bits set");

  host_fill_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hostWrOk |=> inData[$past(hostReq.slot)] == $past(hostReq.data))
    else $error("host byte not stored");

  cs_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode == parallel_port_pkg::MODE_MASTER
    && ctrl[parallel_port_pkg::CTRL_CS_ENABLE] && $stable(outData[1])
    |=> chipSelect == $past(outData[1][7:6]))
    else $error("chip select mismatch");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|(evStat & evMask)) |=> irq)
    else $error("interrupt not raised");

endmodule : parallel_port_buffer_status

/* File: core/parallel_port_pkg.sv */
package parallel_port_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] INPUT_DATA_BASE  = 12'hf00;
  localparam logic [11:0] OUTPUT_DATA_BASE = 12'hf10;
  localparam logic [11:0] CONTROL_ADDR     = 12'hf40;
  localparam logic [11:0] INPUT_STAT_ADDR  = 12'hf50;
  localparam logic [11:0] OUTPUT_STAT_ADDR = 12'hf54;
  localparam logic [11:0] EVENT_STAT_ADDR  = 12'hf58;
  localparam logic [11:0] EVENT_MASK_ADDR  = 12'hf5c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ALL_BIT        = 7;
  localparam int FLOW_BIT       = 6;
  localparam int CTRL_MASTER    = 0;
  localparam int CTRL_BUFFERED  = 1;
  localparam int CTRL_CS_ENABLE = 2;
  localparam int CTRL_TTL       = 3;
  localparam int EV_IN_WRITE    = 0;
  localparam int EV_OUT_READ    = 1;
  localparam int EV_OVERFLOW    = 2;
  localparam int EV_UNDERFLOW   = 3;

  // ----------------------------------------------------------------
  // reset values and slot groups
  // ----------------------------------------------------------------
  localparam logic [3:0] IN_FULL_RESET   = 4'h0;
  localparam logic [3:0] OUT_EMPTY_RESET = 4'hf;
  localparam logic [3:0] CTRL_RESET      = 4'h0;
  localparam logic [3:0] PAIR_SLOTS      = 4'h3;
  localparam logic [3:0] ALL_SLOTS       = 4'hf;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] slot;
    logic [7:0] data;
  } host_req_t;

  typedef enum logic [1:0] {
    MODE_SLAVE    = 2'b00,
    MODE_BUFFERED = 2'b01,
    MODE_MASTER   = 2'b10
  } port_mode_t;

endpackage : parallel_port_pkg

/* File: tb/parallel_host_model.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// external host driving the port strobes
// ----------------------------------------------------------------
module parallel_host_model (
  input  wire logic                    ref_clk,
  output parallel_port_pkg::host_req_t hostReq,
  input  wire logic [7:0]              hostRdData
);

  initial hostReq = '0;

  // one-cycle write strobe, data line inverted once released
  task automatic host_write(input logic [1:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    hostReq <= '{wr: 1'b1, rd: 1'b0, slot: s, data: d};
    @(posedge ref_clk);
    hostReq <= '{wr: 1'b0, rd: 1'b0, slot: ~s, data: ~d};
  endtask : host_write

  // one-cycle read strobe, data taken the cycle after
  task automatic host_read(input logic [1:0] s, output logic [7:0] d);
    @(posedge ref_clk);
    hostReq <= '{wr: 1'b0, rd: 1'b1, slot: s, data: ~hostReq.data};
    @(posedge ref_clk);
    hostReq <= '{wr: 1'b0, rd: 1'b0, slot: ~s, data: hostReq.data};
    @(posedge ref_clk);
    d = hostRdData;
  endtask : host_read

endmodule : parallel_host_model

/* File: tb/parallel_port_buffer_status_tb.sv */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module parallel_port_buffer_status_tb;
  logic        ref_clk, rst_n, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        ttlInputSelect, irq, ovf, unf;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d32;
  logic [3:0]  wstrb, inFull, outEmpty, ev, mask, ctrl;
  logic [1:0]  bresp, rresp, chipSelect, r;
  logic [7:0]  hostRdData, hrd, inData[4], outData[4];
  logic [15:0] addrOut;
  int          num_errors, n_tests, cycles;
  parallel_port_pkg::host_req_t hostReq;

  parallel_port_buffer_status parallel_port_buffer_status_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hostReq(hostReq), .hostRdData(hostRdData),
    .addrOut(addrOut), .chipSelect(chipSelect),
    .ttlInputSelect(ttlInputSelect), .irq(irq));

  parallel_host_model parallel_host_model_inst (
    .ref_clk(ref_clk), .hostReq(hostReq), .hostRdData(hostRdData));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // compare, bus and model tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : check

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           output logic [1:0] rs);
    logic aw;
    logic w;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] rs);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axi_write(a, d, r);
    check("write response", {30'h0, parallel_port_pkg::RESP_OKAY}, {30'h0, r});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, string nm);
    axi_read(a, d32, r);
    check("read response", {30'h0, parallel_port_pkg::RESP_OKAY}, {30'h0, r});
    check(nm, e, d32);
  endtask : rd

  function automatic logic [3:0] wmask();
    return (ctrl[1] && !ctrl[0]) ? 4'hf : 4'h3;
  endfunction : wmask

  function automatic logic [3:0] rmask();
    return ctrl[0] ? 4'h0 : (ctrl[1] ? 4'hf : 4'h3);
  endfunction : rmask

  task automatic check_all();
    rd(parallel_port_pkg::INPUT_STAT_ADDR, {24'h0, (inFull & wmask()) ==
       wmask(), ovf, 2'b00, inFull}, "input status");
    rd(parallel_port_pkg::OUTPUT_STAT_ADDR, {24'h0, (outEmpty & rmask()) ==
       rmask(), unf, 2'b00, outEmpty}, "output status");
    rd(parallel_port_pkg::EVENT_STAT_ADDR, {28'h0, ev}, "event status");
    check("irq", {31'h0, |(ev & mask)}, {31'h0, irq});
  endtask : check_all

  task automatic hw(input logic [1:0] s, input logic [7:0] d);
    logic [3:0] m;
    m = wmask();
    parallel_host_model_inst.host_write(s, d);
    if (m[s] && inFull[s]) begin
      ovf = 1'b1;
      ev[2] = 1'b1;
    end else if (m[s]) begin
      inData[s] = d;
      inFull[s] = 1'b1;
      ev[0] = 1'b1;
    end
  endtask : hw

  task automatic hr(input logic [1:0] s);
    logic [7:0] d;
    logic [3:0] m;
    m = rmask();
    parallel_host_model_inst.host_read(s, d);
    if (m[s] && outEmpty[s]) begin
      unf = 1'b1;
      ev[3] = 1'b1;
    end else if (m[s]) begin
      check("host data", {24'h0, outData[s]}, {24'h0, d});
      outEmpty[s] = 1'b1;
      ev[1] = 1'b1;
    end
  endtask : hr

  task automatic cin(input logic [1:0] s);
    rd(parallel_port_pkg::INPUT_DATA_BASE + {8'h0, s, 2'b00},
       {24'h0, inData[s]}, "input data");
    inFull[s] = 1'b0;
  endtask : cin

  task automatic cout(input logic [1:0] s, input logic [7:0] d);
    wr(parallel_port_pkg::OUTPUT_DATA_BASE + {8'h0, s, 2'b00}, {24'h0, d});
    outData[s] = d;
    outEmpty[s] = 1'b0;
  endtask : cout

  task automatic set_ctrl(input logic [3:0] c);
    wr(parallel_port_pkg::CONTROL_ADDR, {28'h0, c});
    ctrl = c;
    repeat (2) @(posedge ref_clk);
  endtask : set_ctrl

  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    {inFull, outEmpty, ev, mask, ctrl, ovf, unf} = {12'h0f0, 10'h0};
  endtask : do_reset

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {num_errors, n_tests, cycles} = '0;
    void'($urandom(99938));
    do_reset();
    check_all();
    axi_read(12'hf30, d32, r);
    check("unmapped read resp", {30'h0, parallel_port_pkg::RESP_SLVERR},
          {30'h0, r});
    check("unmapped read data", 32'h0, d32);
    axi_write(12'hf34, 32'hff, r);
    check("unmapped write", {30'h0, parallel_port_pkg::RESP_SLVERR},
          {30'h0, r});
    wr(parallel_port_pkg::EVENT_MASK_ADDR, 32'h1);
    mask = 4'h1;
    // low byte lane off: register keeps its value
    wstrb <= 4'he;
    wr(parallel_port_pkg::EVENT_MASK_ADDR, 32'hf);
    wstrb <= 4'hf;
    rd(parallel_port_pkg::EVENT_MASK_ADDR, 32'h1, "event mask");
    // slave: fill, overflow, ignored slot, cpu read
    for (int s = 0; s < 2; s++) begin
      hw(2'(s), 8'($urandom));
      check_all();
    end
    hw(2'd0, 8'($urandom));
    hw(2'd2, 8'($urandom));
    check_all();
    cin(2'd0);
    check_all();
    wr(parallel_port_pkg::INPUT_STAT_ADDR, 32'h0);
    ovf = 1'b0;
    cout(2'd0, 8'($urandom));
    check_all();
    hr(2'd0);
    hr(2'd0);
    hr(2'd2);
    check_all();
    wr(parallel_port_pkg::OUTPUT_STAT_ADDR, 32'h0);
    unf = 1'b0;
    wr(parallel_port_pkg::EVENT_STAT_ADDR, 32'hf);
    ev = 4'h0;
    cin(2'd1);
    check_all();
    // buffered slave: all four slots both ways
    set_ctrl(4'h2);
    for (int s = 0; s < 4; s++) hw(2'(s), 8'($urandom));
    check_all();
    for (int s = 0; s < 4; s++) cin(2'(s));
    for (int s = 0; s < 4; s++) cout(2'(s), 8'($urandom));
    check_all();
    for (int s = 0; s < 4; s++) hr(2'(s));
    check_all();
    // master: shared pair as address and chip selects
    set_ctrl(4'h5);
    cout(2'd1, 8'hc5);
    cout(2'd0, 8'h3a);
    hw(2'd0, 8'($urandom));
    parallel_host_model_inst.host_read(2'd0, hrd);
    check("master host data", {24'h0, inData[0]}, {24'h0, hrd});
    check_all();
    check("address", 32'h053a, {16'h0, addrOut});
    check("chip select", 32'h3, {30'h0, chipSelect});
    set_ctrl(4'h1);
    check("address", 32'hc53a, {16'h0, addrOut});
    check("chip select", 32'h0, {30'h0, chipSelect});
    set_ctrl(4'h8);
    check("ttl select", 32'h1, {31'h0, ttlInputSelect});
    check("address", 32'h0, {16'h0, addrOut});
    do_reset();
    check_all();
    check("ttl select", 32'h0, {31'h0, ttlInputSelect});
    finish_test();
  end

endmodule : parallel_port_buffer_status_tb
